// ===== hdl/fdp_pkg.sv
// Constants, layouts and types of the FIFO DMA port handshake block
// How it works
// - Request pin level follows request polarity
// - Cycle steal: one request per unit
// - Burst: request held until all done
// - Request pin driven only when enabled
// - Acknowledge read at selected polarity
// - Strobe mode counts only with acknowledge pin
// - Acknowledge pin off blocks split bus
// - End pin polarity for drive and sample
// - Count done or short packet ends transfer
// - Packet mode: buffer done ends transfer
// - IN direction ignores packet mode
// - End pin disabled: released and unused
// - End pin output for OUT, input IN
// - Bus mode 0: drive always for OUT
// - Bus mode 1: drive during ack and strobe
// - Sixteen bit CPU data port at 0x14
// - Port bits kept in D0 to D15 order
// - Pipe direction picks receive or transmit
// - Control pipe takes direction from select bit
// - Burst bit 0 steal, 1 burst
package fdp_pkg;

	// ------------------------------------------------
	// Register map
	// ------------------------------------------------
	localparam logic [7:0]  CFG_ADDR  = 8'h0C;
	localparam logic [7:0]  DATA_ADDR = 8'h14;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] CFG_WMASK = 16'h7774;
	localparam logic [15:0] RD_ZERO   = 16'h0000;
	localparam logic [2:0]  CTRL_PIPE = 3'h0;

	// ------------------------------------------------
	// Configuration field positions
	// ------------------------------------------------
	localparam int unsigned REQ_POL_BIT  = 14;
	localparam int unsigned BURST_BIT    = 13;
	localparam int unsigned REQ_OE_BIT   = 12;
	localparam int unsigned ACK_POL_BIT  = 10;
	localparam int unsigned STRB_BIT     = 9;
	localparam int unsigned ACK_PIN_BIT  = 8;
	localparam int unsigned END_POL_BIT  = 6;
	localparam int unsigned PKT_MODE_BIT = 5;
	localparam int unsigned END_EN_BIT   = 4;
	localparam int unsigned OUT_BUS_BIT  = 2;

	// ------------------------------------------------
	// Types
	// ------------------------------------------------
	typedef struct packed {
		logic req_pol;
		logic burst;
		logic req_oe;
		logic ack_pol;
		logic strb_mode;
		logic ack_pin;
		logic end_pol;
		logic pkt_mode;
		logic end_en;
		logic out_bus;
	} fdp_cfg_t;

	typedef struct packed {
		logic        cs;
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} fdp_cpu_req_t;

	typedef enum logic [1:0] {
		REQ_IDLE = 2'b00,
		REQ_ON   = 2'b01,
		REQ_WAIT = 2'b11
	} fdp_req_state_t;

endpackage

// ===== hdl/fdp_cfg_reg.sv
// Pin control configuration register
`timescale 1ns/1ps
`default_nettype none
module fdp_cfg_reg
	import fdp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Write side
	input  wire logic        wr_i,
	input  wire logic [15:0] wdata_i,
	// Contents
	output logic [15:0]      word_o,
	output fdp_cfg_t         cfg_o
);

	// ------------------------------------------------
	// Storage
	// ------------------------------------------------
	logic [15:0] word;
	wire  [15:0] next_word = wdata_i & CFG_WMASK;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			word <= CFG_RESET;
		end else if (wr_i) begin
			word <= next_word;
		end
	end

	// ------------------------------------------------
	// Field split
	// ------------------------------------------------
	assign word_o          = word;
	assign cfg_o.req_pol   = word[REQ_POL_BIT];
	assign cfg_o.burst     = word[BURST_BIT];
	assign cfg_o.req_oe    = word[REQ_OE_BIT];
	assign cfg_o.ack_pol   = word[ACK_POL_BIT];
	assign cfg_o.strb_mode = word[STRB_BIT];
	assign cfg_o.ack_pin   = word[ACK_PIN_BIT];
	assign cfg_o.end_pol   = word[END_POL_BIT];
	assign cfg_o.pkt_mode  = word[PKT_MODE_BIT];
	assign cfg_o.end_en    = word[END_EN_BIT];
	assign cfg_o.out_bus   = word[OUT_BUS_BIT];

endmodule // fdp_cfg_reg
`default_nettype wire

// ===== hdl/fdp_req_gen.sv
// DMA request sequencer, cycle steal or burst
`timescale 1ns/1ps
`default_nettype none
module fdp_req_gen
	import fdp_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// Control
	input  wire logic burst_i,
	input  wire logic unit_avail_i,
	input  wire logic all_done_i,
	input  wire logic ack_act_i,
	// Request
	output logic      req_act_o
);

	// ------------------------------------------------
	// Sequencer
	// ------------------------------------------------
	fdp_req_state_t state;
	fdp_req_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			REQ_IDLE: begin
				if (unit_avail_i && !all_done_i) begin
					next_state = REQ_ON;
				end
			end
			REQ_ON: begin
				if (burst_i) begin
					if (all_done_i) begin
						next_state = REQ_IDLE;
					end
				end else if (ack_act_i) begin
					next_state = REQ_WAIT;
				end
			end
			REQ_WAIT: begin
				// Waits for the acknowledge to drop so one unit gives one request
				if (!ack_act_i) begin
					next_state = REQ_IDLE;
				end
			end
			default: begin
				next_state = REQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= REQ_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign req_act_o = (state == REQ_ON);

endmodule // fdp_req_gen
`default_nettype wire

// ===== hdl/fdp_port.sv
// FIFO DMA port handshake, pin control and CPU data port
`timescale 1ns/1ps
`default_nettype none
module fdp_port
	import fdp_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	// CPU register access
	input  wire fdp_cpu_req_t  cpu_i,
	output logic [15:0]        cpu_rdata_o,
	// Pipe selection
	input  wire logic [2:0]    cur_pipe_i,
	input  wire logic          pipe_dir_i,
	input  wire logic          ctrl_pipe_dir_sel_i,
	input  wire logic          dma_pipe_dir_i,
	// CPU port transmit stream
	output logic [15:0]        tx_data_o,
	output logic               tx_valid_o,
	input  wire logic          tx_ready_i,
	// CPU port receive stream
	input  wire logic [15:0]   rx_data_i,
	input  wire logic          rx_valid_i,
	output logic               rx_ready_o,
	// DMA FIFO side
	input  wire logic          dma_unit_avail_i,
	input  wire logic          dma_all_done_i,
	input  wire logic [7:0]    dma_rdata_i,
	output logic               dma_pop_o,
	output logic [7:0]         dma_wdata_o,
	output logic               dma_push_o,
	// End of transfer causes and report
	input  wire logic          pkt_count_done_i,
	input  wire logic          short_pkt_i,
	input  wire logic          buf_done_i,
	output logic               xfer_end_seen_o,
	// Handshake pins
	output logic               dreq_o,
	output logic               dreq_oe_o,
	input  wire logic          dack_i,
	input  wire logic          cpu_dma_ack_i,
	input  wire logic          dma_strobe_n_i,
	input  wire logic          rd_n_i,
	input  wire logic          wr_n_i,
	// Split bus data pins
	input  wire logic [7:0]    sd_i,
	output logic [7:0]         sd_o,
	output logic               sd_oe_o,
	// End of transfer pin
	input  wire logic          xfer_end_pin_i,
	output logic               xfer_end_pin_o,
	output logic               xfer_end_pin_oe_o
);

	// ------------------------------------------------
	// Address decode
	// ------------------------------------------------
	wire cfg_hit  = cpu_i.cs && (cpu_i.addr == CFG_ADDR);
	wire data_hit = cpu_i.cs && (cpu_i.addr == DATA_ADDR);
	wire cfg_wr   = cfg_hit && cpu_i.wr;
	wire data_wr  = data_hit && cpu_i.wr;
	wire data_rd  = data_hit && cpu_i.rd;

	// ------------------------------------------------
	// Configuration register
	// ------------------------------------------------
	fdp_cfg_t    cfg;
	logic [15:0] cfg_word;

	fdp_cfg_reg u_cfg (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.wr_i    (cfg_wr),
		.wdata_i (cpu_i.wdata),
		.word_o  (cfg_word),
		.cfg_o   (cfg)
	);

	// ------------------------------------------------
	// CPU port direction
	// ------------------------------------------------
	wire ctrl_sel = (cur_pipe_i == CTRL_PIPE);
	// Control pipe has no fixed direction, so the select bit stands in for it
	wire cpu_tx   = ctrl_sel ? ctrl_pipe_dir_sel_i
	                         : pipe_dir_i;
	wire cpu_push = data_wr && cpu_tx && !tx_valid_o;
	wire cpu_pop  = data_rd && !cpu_tx;

	// ------------------------------------------------
	// CPU transmit holding register
	// ------------------------------------------------
	// A write while the previous word is still pending is dropped
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_valid_o <= 1'b0;
		end else if (cpu_push) begin
			tx_valid_o <= 1'b1;
		end else if (tx_ready_i) begin
			tx_valid_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_data_o <= RD_ZERO;
		end else if (cpu_push) begin
			tx_data_o <= cpu_i.wdata;
		end
	end

	// ------------------------------------------------
	// CPU receive holding register
	// ------------------------------------------------
	logic        rx_full;
	logic [15:0] rx_hold;
	wire         rx_load = rx_valid_i && !rx_full;

	assign rx_ready_o = !rx_full;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_full <= 1'b0;
		end else if (rx_load) begin
			rx_full <= 1'b1;
		end else if (cpu_pop) begin
			rx_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_hold <= RD_ZERO;
		end else if (rx_load) begin
			rx_hold <= rx_data_i;
		end
	end

	// ------------------------------------------------
	// Read data
	// ------------------------------------------------
	wire [15:0] data_rval = cpu_tx ? RD_ZERO : rx_hold;
	wire [15:0] next_rdata = cfg_hit  ? cfg_word
	                       : data_hit ? data_rval
	                       : RD_ZERO;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cpu_rdata_o <= RD_ZERO;
		end else if (cpu_i.cs && cpu_i.rd) begin
			cpu_rdata_o <= next_rdata;
		end
	end

	// ------------------------------------------------
	// Handshake decode
	// ------------------------------------------------
	wire dma_out  = !dma_pipe_dir_i;
	wire dma_in   = dma_pipe_dir_i;
	wire dack_act = (dack_i == cfg.ack_pol);
	// Without the acknowledge pin the CPU bus cycle is the handshake
	wire ack_act  = cfg.ack_pin ? dack_act : cpu_dma_ack_i;
	wire split_en = cfg.ack_pin;
	wire use_dstb = cfg.ack_pin && cfg.strb_mode;
	wire rw_act   = dma_out ? !rd_n_i : !wr_n_i;
	wire strb_act = use_dstb ? !dma_strobe_n_i : rw_act;
	wire cyc_act  = ack_act && strb_act;

	// ------------------------------------------------
	// Request sequencer and pin
	// ------------------------------------------------
	logic req_act;

	fdp_req_gen u_req (
		.clk_i        (clk_i),
		.nrst_i       (nrst_i),
		.burst_i      (cfg.burst),
		.unit_avail_i (dma_unit_avail_i),
		.all_done_i   (dma_all_done_i),
		.ack_act_i    (ack_act),
		.req_act_o    (req_act)
	);

	wire req_live = req_act && cfg.req_oe;
	wire req_lvl  = cfg.req_pol ? req_live : !req_live;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dreq_o    <= 1'b1;
			dreq_oe_o <= 1'b0;
		end else begin
			dreq_o    <= req_lvl;
			dreq_oe_o <= cfg.req_oe;
		end
	end

	// ------------------------------------------------
	// Split bus transfer strobe
	// ------------------------------------------------
	logic cyc_q;
	// Data moves at the trailing edge so the pins have settled
	wire  cyc_done = cyc_q && !cyc_act && split_en;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cyc_q <= 1'b0;
		end else begin
			cyc_q <= cyc_act;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dma_pop_o  <= 1'b0;
			dma_push_o <= 1'b0;
		end else begin
			dma_pop_o  <= cyc_done && dma_out;
			dma_push_o <= cyc_done && dma_in;
		end
	end

	// Input data is caught while the strobe is active
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dma_wdata_o <= 8'h00;
		end else if (cyc_act && dma_in && split_en) begin
			dma_wdata_o <= sd_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sd_o <= 8'h00;
		end else begin
			sd_o <= dma_rdata_i;
		end
	end

	// ------------------------------------------------
	// Pin drive windows
	// ------------------------------------------------
	wire drive_win = cfg.out_bus ? cyc_act : 1'b1;
	wire sd_drive  = split_en && dma_out && drive_win;
	wire end_drive = cfg.end_en && dma_out && drive_win;
	wire in_win    = cfg.out_bus ? ack_act : 1'b1;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sd_oe_o           <= 1'b0;
			xfer_end_pin_oe_o <= 1'b0;
		end else begin
			sd_oe_o           <= sd_drive;
			xfer_end_pin_oe_o <= end_drive;
		end
	end

	// ------------------------------------------------
	// End of transfer, OUT direction
	// ------------------------------------------------
	wire eot_cause = cfg.pkt_mode ? buf_done_i
	                              : (pkt_count_done_i || short_pkt_i);
	wire eot_set   = cfg.end_en && dma_out && eot_cause;
	logic end_pend;

	// A cause that lands on the closing strobe keeps the flag set
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			end_pend <= 1'b0;
		end else if (eot_set) begin
			end_pend <= 1'b1;
		end else if (cyc_done || !cfg.end_en) begin
			end_pend <= 1'b0;
		end
	end

	wire end_lvl = cfg.end_pol ? end_pend : !end_pend;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			xfer_end_pin_o <= 1'b1;
		end else begin
			xfer_end_pin_o <= end_lvl;
		end
	end

	// ------------------------------------------------
	// End of transfer, IN direction
	// ------------------------------------------------
	wire end_in_act = (xfer_end_pin_i == cfg.end_pol);
	wire end_in_ok  = cfg.end_en && dma_in && in_win;
	wire end_in_now = end_in_ok && end_in_act;
	logic end_in_q;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			end_in_q        <= 1'b0;
			xfer_end_seen_o <= 1'b0;
		end else begin
			end_in_q        <= end_in_now;
			xfer_end_seen_o <= end_in_now && !end_in_q;
		end
	end

endmodule // fdp_port
`default_nettype wire

// ===== testbench/fdp_port_props.sv
// Checker of the DMA pin control and CPU data port
`timescale 1ns/1ps
`default_nettype none
module fdp_port_props
	import fdp_pkg::*;
(
	// Clock and reset
	input wire logic         clk_i,
	input wire logic         nrst_i,
	// Watched ports
	input wire fdp_cpu_req_t cpu_i,
	input wire logic [15:0]  cpu_rdata_o,
	input wire logic [2:0]   cur_pipe_i,
	input wire logic         pipe_dir_i,
	input wire logic         ctrl_pipe_dir_sel_i,
	input wire logic         dma_pipe_dir_i,
	input wire logic [15:0]  tx_data_o,
	input wire logic         tx_valid_o,
	input wire logic         dreq_o,
	input wire logic         dreq_oe_o,
	input wire logic         sd_oe_o,
	input wire logic         xfer_end_pin_oe_o
);
	logic [15:0] cfg;
	logic [1:0]  stab;
	logic        cfg_wr;
	logic        tx_dir;
	logic        settled;
	assign cfg_wr  = cpu_i.cs && cpu_i.wr && cpu_i.addr == CFG_ADDR;
	assign tx_dir  = (cur_pipe_i == CTRL_PIPE) ? ctrl_pipe_dir_sel_i : pipe_dir_i;
	assign settled = stab == 2'h3;

	// Shadow of the settings; pins lag a write by two registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg  <= CFG_RESET;
			stab <= 2'h0;
		end else if (cfg_wr) begin
			cfg  <= cpu_i.wdata & CFG_WMASK;
			stab <= 2'h0;
		end else if (!settled) begin
			stab <= stab + 2'h1;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence dat_wr_s;
		cpu_i.cs && cpu_i.wr && cpu_i.addr == DATA_ADDR && !tx_valid_o;
	endsequence

	cfg_read_a: assert property (cpu_i.cs && cpu_i.rd && cpu_i.addr == CFG_ADDR |=> cpu_rdata_o == cfg)
		else $error("settings readback wrong");
	unmapped_read_a: assert property (cpu_i.cs && cpu_i.rd && cpu_i.addr != CFG_ADDR && cpu_i.addr != DATA_ADDR
		|=> cpu_rdata_o == RD_ZERO) else $error("unmapped read not zero");
	tx_accept_a: assert property (dat_wr_s ##0 tx_dir |=> tx_valid_o && tx_data_o == $past(cpu_i.wdata))
		else $error("transmit word lost");
	rx_refuse_a: assert property (dat_wr_s ##0 !tx_dir |=> !tx_valid_o)
		else $error("write taken in receive direction");
	req_oe_a: assert property (settled |-> dreq_oe_o == cfg[REQ_OE_BIT])
		else $error("request enable wrong");
	req_idle_a: assert property (settled && !cfg[REQ_OE_BIT] |-> dreq_o == !cfg[REQ_POL_BIT])
		else $error("request idle level wrong");
	split_off_a: assert property (settled && !cfg[ACK_PIN_BIT] |-> !sd_oe_o)
		else $error("split bus driven");
	end_off_a: assert property (settled && !cfg[END_EN_BIT] |-> !xfer_end_pin_oe_o)
		else $error("end pin driven while off");
	end_in_a: assert property (settled && dma_pipe_dir_i && $past(dma_pipe_dir_i) |-> !xfer_end_pin_oe_o)
		else $error("end pin driven for IN");
	split_drive_a: assert property (settled && cfg[ACK_PIN_BIT] && !cfg[OUT_BUS_BIT] && !dma_pipe_dir_i
		&& !$past(dma_pipe_dir_i) |-> sd_oe_o) else $error("split bus not driven");
endmodule // fdp_port_props

bind fdp_port fdp_port_props u_props (.clk_i, .nrst_i, .cpu_i, .cpu_rdata_o, .cur_pipe_i, .pipe_dir_i,
	.ctrl_pipe_dir_sel_i, .dma_pipe_dir_i, .tx_data_o, .tx_valid_o, .dreq_o, .dreq_oe_o, .sd_oe_o,
	.xfer_end_pin_oe_o);
`default_nettype wire

// ===== testbench/fdp_dma_model.sv
// External DMA controller answering the request pin
`timescale 1ns/1ps
`default_nettype none
module fdp_dma_model (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       dreq_i,
	input  wire logic       dreq_oe_i,
	input  wire logic       req_pol_i,
	input  wire logic       ack_pol_i,
	output logic            dack_o,
	output logic            strobe_n_o,
	output logic [7:0]      sd_o
);
	logic       act;
	logic [2:0] gap;
	// Gap lets the request pin fall before the next unit is granted
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			act <= 1'b0;
			gap <= 3'h0;
			sd_o <= 8'h5A;
		end else begin
			sd_o <= ~sd_o;
			if (act) begin
				act <= 1'b0;
				gap <= 3'h4;
			end else if (gap != 3'h0) begin
				gap <= gap - 3'h1;
			end else begin
				act <= dreq_oe_i && dreq_i == req_pol_i;
			end
		end
	end
	assign dack_o     = act ? ack_pol_i : !ack_pol_i;
	assign strobe_n_o = !act;
endmodule // fdp_dma_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench of the FIFO DMA port block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fdp_pkg::*;
	logic clk_i, nrst_i, pdir, csel, ddir, txr, rxv, avail, done, endi, dack, dma_strobe_n, prev, seen, oes, cack;
	logic [2:0] pipe, cause;
	logic [15:0] cfgw, rxd, rdat, txd;
	logic [7:0] sdi, sdo, wdat;
	logic pop, push, eseen, dreq, dreq_oe, rxr, txv, sd_oe, eo, eoe;
	fdp_cpu_req_t cpu;
	int n_mismatch, n_tests, pops, falls, pushes;
	logic [15:0] ecf [5] = '{16'h5750, 16'h5750, 16'h5770, 16'h5770, 16'h5710};
	logic [2:0] ecs [5] = '{3'b100, 3'b010, 3'b001, 3'b100, 3'b100};
	logic       eex [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

	fdp_port u_dut (.clk_i, .nrst_i, .cpu_i(cpu), .cpu_rdata_o(rdat), .cur_pipe_i(pipe), .pipe_dir_i(pdir),
		.ctrl_pipe_dir_sel_i(csel), .dma_pipe_dir_i(ddir), .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(txr),
		.rx_data_i(rxd), .rx_valid_i(rxv), .rx_ready_o(rxr), .dma_unit_avail_i(avail), .dma_all_done_i(done),
		.dma_rdata_i(8'hA5), .dma_pop_o(pop), .dma_wdata_o(wdat), .dma_push_o(push),
		.pkt_count_done_i(cause[2]), .short_pkt_i(cause[1]), .buf_done_i(cause[0]), .xfer_end_seen_o(eseen),
		.dreq_o(dreq), .dreq_oe_o(dreq_oe), .dack_i(dack), .cpu_dma_ack_i(cack), .dma_strobe_n_i(dma_strobe_n),
		.rd_n_i(1'b1), .wr_n_i(1'b1), .sd_i(sdi), .sd_o(sdo), .sd_oe_o(sd_oe), .xfer_end_pin_i(endi),
		.xfer_end_pin_o(eo), .xfer_end_pin_oe_o(eoe));
	fdp_dma_model u_dma (.clk_i, .nrst_i, .dreq_i(dreq), .dreq_oe_i(dreq_oe), .req_pol_i(cfgw[14]),
		.ack_pol_i(cfgw[10]), .dack_o(dack), .strobe_n_o(dma_strobe_n), .sd_o(sdi));

	always #2.5 clk_i = ~clk_i;

	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		cpu = '{1'b1, 1'b1, 1'b0, a, d};
		@(negedge clk_i);
		cpu = '0;
		// Idle cycle so a following access never drives the request twice in one step
		@(negedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		cpu = '{1'b1, 1'b0, 1'b1, a, 16'h0000};
		@(negedge clk_i);
		cpu = '0;
		chk(rdat === e, "read data");
		@(negedge clk_i);
	endtask
	task automatic setcfg(input logic [15:0] d);
		cfgw = d;
		wr(CFG_ADDR, d);
	endtask
	// Bounded observation window; counts grants and request drops
	task automatic run(input int n);
		pops = 0;
		pushes = 0;
		falls = 0;
		seen = 0;
		oes = 0;
		repeat (n) begin
			@(negedge clk_i);
			pops += int'(pop === 1'b1);
			pushes += int'(push === 1'b1);
			falls += int'(prev === 1'b1 && dreq === 1'b0);
			prev = dreq;
			seen |= eseen === 1'b1;
			oes |= sd_oe === 1'b1;
		end
	endtask
	task automatic drain;
		txr = 1;
		run(1);
		txr = 0;
		run(1);
		chk(txv === 1'b0, "transmit not drained");
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		{clk_i, nrst_i, pdir, csel, ddir, txr, rxv, avail, done, endi, prev, cause, cack} = '0;
		{cfgw, rxd, n_mismatch, n_tests} = '0;
		cpu = '0;
		pipe = 3'h1;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		nrst_i = 1;
		rd(CFG_ADDR, CFG_RESET);
		setcfg(16'hFFFF);
		rd(CFG_ADDR, CFG_WMASK);
		rd(8'h30, RD_ZERO);
		$display("test registers done");
		pdir = 1;
		wr(DATA_ADDR, 16'h8001);
		wr(DATA_ADDR, 16'h1234);
		chk(txv === 1'b1 && txd === 16'h8001, "transmit word");
		drain;
		pipe = CTRL_PIPE;
		csel = 1;
		wr(DATA_ADDR, 16'hA55A);
		chk(txv === 1'b1 && txd === 16'hA55A, "control transmit");
		drain;
		csel = 0;
		rxd = 16'hC3A5;
		rxv = 1;
		run(1);
		rxv = 0;
		chk(rxr === 1'b0, "receive holding full");
		rd(DATA_ADDR, 16'hC3A5);
		chk(rxr === 1'b1, "receive holding freed");
		{pipe, pdir} = {3'h2, 1'b0};
		wr(DATA_ADDR, 16'h0F0F);
		chk(txv === 1'b0, "receive write taken");
		pdir = 1;
		rd(DATA_ADDR, RD_ZERO);
		$display("test cpu port done");
		for (int p = 0; p < 2; p++) begin
			setcfg(p ? 16'h5000 : 16'h1000);
			run(4);
			chk(dreq === !p, "request idle level");
			setcfg(p ? 16'h5700 : 16'h5300);
			avail = 1;
			run(80);
			chk(pops >= 3 && falls >= 3, "steal grants");
			avail = 0;
			run(10);
		end
		setcfg(16'h7700);
		avail = 1;
		run(10);
		run(50);
		chk(pops >= 3 && falls == 0, "burst held");
		done = 1;
		run(6);
		chk(dreq === 1'b0, "burst end");
		{done, avail} = '0;
		$display("test request done");
		for (int p = 0; p < 2; p++) begin
			// Acknowledge pin off (p=0), or bus mode 1 with no strobe able to complete (p=1), keeps the split bus released
			setcfg(p ? 16'h5504 : 16'h5200);
			avail = 1;
			run(30);
			chk(pops == 0 && oes === 1'b0, "strobe or pin select");
			avail = 0;
			cack = !p;
			run(1);
			cack = 0;
			run(5);
			if (p == 0) chk(falls == 1 && pops == 0, "CPU bus acknowledge");
		end
		setcfg(16'h5704);
		run(4);
		chk(sd_oe === 1'b0, "bus mode 1 idle");
		avail = 1;
		run(40);
		chk(oes === 1'b1, "bus mode 1 strobe");
		avail = 0;
		setcfg(16'h5700);
		run(6);
		chk(sd_oe === 1'b1 && sdo === 8'hA5, "bus mode 0 OUT");
		ddir = 1;
		run(4);
		chk(sd_oe === 1'b0, "bus mode 0 IN");
		avail = 1;
		run(30);
		chk(pushes >= 2 && pops == 0 && (wdat === 8'h5A || wdat === 8'hA5), "IN unit pushed");
		avail = 0;
		run(10);
		ddir = 0;
		for (int i = 0; i < 5; i++) begin
			setcfg(16'h5740);
			setcfg(ecf[i]);
			cause = ecs[i];
			run(1);
			cause = 0;
			run(3);
			chk(eo === eex[i] && eoe === 1'b1, "end pin out");
		end
		setcfg(16'h5740);
		run(3);
		chk(eoe === 1'b0, "end pin off");
		ddir = 1;
		setcfg(16'h5770);
		run(3);
		chk(eoe === 1'b0, "end pin IN");
		endi = 1;
		run(5);
		endi = 0;
		chk(seen === 1'b1, "end pin sampled");
		setcfg(16'h5740);
		endi = 1;
		run(5);
		endi = 0;
		chk(seen === 1'b0, "end pin unused");
		$display("test end pin done");
		final_report;
	end
endmodule // testbench
`default_nettype wire
